/* hdl/dpram_pkg.sv */
`default_nettype none
package dpram_pkg;
  // register map on the bus
  localparam int HADDR_W = 12;
  localparam logic [HADDR_W-1:0] ADDR_CFG = 12'h000;
  localparam logic [HADDR_W-1:0] ADDR_STAT = 12'h004;
  // configuration fields
  localparam int CFG_W = 9;
  localparam int CFG_WIDTH_LSB = 0;
  localparam int CFG_NINE = 2;
  localparam int CFG_COMB = 3;
  localparam int CFG_BYP_A = 4;
  localparam int CFG_BYP_B = 5;
  localparam int CFG_IN_SEL = 6;
  localparam int CFG_OUT_SEL = 7;
  localparam int CFG_INDEP = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 9'h106;
  // width codes and the lanes each one opens
  localparam logic [1:0] WIDTH_X18 = 2'h0;
  localparam logic [1:0] WIDTH_X36 = 2'h1;
  localparam logic [1:0] WIDTH_X72 = 2'h2;
  localparam logic [15:0] LANES_X18 = 16'h0003;
  localparam logic [15:0] LANES_X36 = 16'h000f;
  localparam logic [15:0] LANES_X72 = 16'h00ff;
  localparam logic [15:0] LANES_X144 = 16'hffff;
  // status fields
  localparam int STAT_CNT_A_LSB = 0;
  localparam int STAT_CNT_B_LSB = 16;
  localparam int PORT_W = 72;
  localparam int WIDE_W = 144;
  localparam int MASK_W = 8;
endpackage
`default_nettype wire

/* hdl/lane_expand.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_expand
  import dpram_pkg::*;
(
  // lane mask in, one bit per lane
  input wire logic [15:0] lane_mask,
  input wire logic nine_bit,
  // per data bit write enable
  output logic [WIDE_W-1:0] bit_mask
);
  always_comb
  begin
    bit_mask = '0;
    for (int i = 0; i < 16; i++)
    begin
      if (nine_bit)
        bit_mask[9*i +: 9] = {9{lane_mask[i]}};
      else
        bit_mask[8*i +: 8] = {8{lane_mask[i]}};
    end
  end
endmodule // lane_expand
`default_nettype wire

/* hdl/dual_port_ram_byte_enable.sv */
// How it works
// - one write select per port, no read enable
// - lane written only with select and mask
// - all-high mask writes every lane
// - x18, x36, x72 use 2, 4, 8 mask bits
// - x144 joins both masks into sixteen
// - mask bit i guards bits 9i+8..9i
// - bits 8..15 continue pattern up to 143
// - any mask pattern, lanes independent
// - eight-bit lanes in 16/32/64/128 widths
// - input and output clocks may differ
// - outside independent mode, input registers share one chosen clock
// - output register can be bypassed
// - each port has 72-bit data in and out
// - independent clocks in true dual-port
// - independent mode: A on clock A, B on B
// - per-port clock enable and async clear
// - every port register async clearable
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_byte_enable
  import dpram_pkg::*;
#(
  parameter int DEPTH = 8192
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [dpram_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // port clocks as one-cycle ticks, enables and clears
  input wire logic tick_a,
  input wire logic tick_b,
  input wire logic clocken_a,
  input wire logic clocken_b,
  input wire logic clr_a,
  input wire logic clr_b,
  // port a
  input wire logic wsel_a,
  input wire logic [$clog2(DEPTH)-1:0] addr_a,
  input wire logic [dpram_pkg::PORT_W-1:0] din_a,
  input wire logic [dpram_pkg::MASK_W-1:0] bmask_a,
  output logic [dpram_pkg::PORT_W-1:0] dout_a,
  // port b
  input wire logic wsel_b,
  input wire logic [$clog2(DEPTH)-1:0] addr_b,
  input wire logic [dpram_pkg::PORT_W-1:0] din_b,
  input wire logic [dpram_pkg::MASK_W-1:0] bmask_b,
  output logic [dpram_pkg::PORT_W-1:0] dout_b
);
  import dpram_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // the pair logic of the joined mode needs an even, power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("DEPTH must be a power of two of at least 2");
  end

  // ---------------- register bus ----------------
  logic [CFG_W-1:0] cfg;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic wr_pend;
  logic [HADDR_W-1:0] wr_addr;
  logic [CFG_W-1:0] cfg_now;
  logic addr_phase;

  assign addr_phase = hsel && htrans[1] && hready;
  // a read right behind a write sees the new value
  assign cfg_now = (wr_pend && wr_addr == ADDR_CFG) ? hwdata[CFG_W-1:0] : cfg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cfg <= CFG_RESET;
    else if (wr_pend && wr_addr == ADDR_CFG)
      cfg <= hwdata[CFG_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite)
      begin
        if (haddr == ADDR_CFG)
          hrdata <= {{(32-CFG_W){1'b0}}, cfg_now};
        else if (haddr == ADDR_STAT)
          hrdata <= {cnt_b, cnt_a};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------- mode decode ----------------
  logic nine;
  logic comb;
  logic indep;
  logic [15:0] lanes;
  logic in_sel_tick;
  logic out_sel_tick;
  logic in_a;
  logic in_b;
  logic out_a;
  logic out_b;

  assign nine = cfg[CFG_NINE];
  // joining the masks only makes sense without independent clocks
  assign comb = cfg[CFG_COMB] && !cfg[CFG_INDEP];
  assign indep = cfg[CFG_INDEP];
  always_comb
  begin
    case (cfg[CFG_WIDTH_LSB +: 2])
      WIDTH_X18: lanes = LANES_X18;
      WIDTH_X36: lanes = LANES_X36;
      default: lanes = LANES_X72;
    endcase
    if (comb)
      lanes = LANES_X144;
  end

  // input and output side pick their clock apart
  assign in_sel_tick = cfg[CFG_IN_SEL] ? tick_b : tick_a;
  assign out_sel_tick = cfg[CFG_OUT_SEL] ? tick_b : tick_a;
  assign in_a = (indep ? tick_a : in_sel_tick) && clocken_a;
  assign in_b = (indep ? tick_b : in_sel_tick) && clocken_b;
  assign out_a = (indep ? tick_a : out_sel_tick) && clocken_a;
  assign out_b = (indep ? tick_b : out_sel_tick) && clocken_b;

  // per-port reset: global reset or the port's own clear
  logic rst_a_n;
  logic rst_b_n;
  assign rst_a_n = hresetn && !clr_a;
  assign rst_b_n = hresetn && !clr_b;

  // ---------------- input registers ----------------
  logic we_qa;
  logic we_qb;
  logic [AW-1:0] addr_qa;
  logic [AW-1:0] addr_qb;
  logic [PORT_W-1:0] din_qa;
  logic [PORT_W-1:0] din_qb;
  logic [MASK_W-1:0] mask_qa;
  logic [MASK_W-1:0] mask_qb;
  logic acc_a;
  logic acc_b;

  always_ff @(posedge hclk or negedge rst_a_n)
  begin
    if (!rst_a_n)
    begin
      we_qa <= 1'b0;
      addr_qa <= '0;
      din_qa <= '0;
      mask_qa <= '0;
      acc_a <= 1'b0;
    end
    else
    begin
      acc_a <= in_a;
      if (in_a)
      begin
        we_qa <= wsel_a;
        addr_qa <= addr_a;
        din_qa <= din_a;
        mask_qa <= bmask_a;
      end
    end
  end

  always_ff @(posedge hclk or negedge rst_b_n)
  begin
    if (!rst_b_n)
    begin
      we_qb <= 1'b0;
      addr_qb <= '0;
      din_qb <= '0;
      mask_qb <= '0;
      acc_b <= 1'b0;
    end
    else
    begin
      acc_b <= in_b;
      if (in_b)
      begin
        we_qb <= wsel_b;
        addr_qb <= addr_b;
        din_qb <= din_b;
        mask_qb <= bmask_b;
      end
    end
  end

  // ---------------- byte masks ----------------
  logic [15:0] lane_a;
  logic [15:0] lane_b;
  logic [WIDE_W-1:0] bits_a;
  logic [WIDE_W-1:0] bits_b;
  logic wr_a;
  logic wr_b;

  assign lane_a = (comb ? {mask_qb, mask_qa} : {8'h00, mask_qa}) & lanes;
  assign lane_b = {8'h00, mask_qb} & lanes;
  assign wr_a = acc_a && we_qa;
  // in the joined mode port b only reads
  assign wr_b = acc_b && we_qb && !comb;

  lane_expand exp_a (
    .lane_mask(lane_a),
    .nine_bit(nine),
    .bit_mask(bits_a)
  );
  lane_expand exp_b (
    .lane_mask(lane_b),
    .nine_bit(nine),
    .bit_mask(bits_b)
  );

  // ---------------- array ----------------
  logic [PORT_W-1:0] mem [DEPTH];
  logic [AW-1:0] lo_a;
  logic [AW-1:0] hi_a;
  logic [AW-1:0] lo_b;
  logic [AW-1:0] hi_b;
  assign lo_a = {addr_qa[AW-1:1], 1'b0};
  assign hi_a = {addr_qa[AW-1:1], 1'b1};
  assign lo_b = {addr_qb[AW-1:1], 1'b0};
  assign hi_b = {addr_qb[AW-1:1], 1'b1};

  // port a is written last, so it wins a same-address collision
  always_ff @(posedge hclk)
  begin
    if (wr_b)
      mem[addr_qb] <= (mem[addr_qb] & ~bits_b[PORT_W-1:0]) | (din_qb & bits_b[PORT_W-1:0]);
    if (wr_a && comb)
    begin
      mem[lo_a] <= (mem[lo_a] & ~bits_a[PORT_W-1:0]) | (din_qa & bits_a[PORT_W-1:0]);
      mem[hi_a] <= (mem[hi_a] & ~bits_a[WIDE_W-1:PORT_W]) | (din_qb & bits_a[WIDE_W-1:PORT_W]);
    end
    else if (wr_a)
      mem[addr_qa] <= (mem[addr_qa] & ~bits_a[PORT_W-1:0]) | (din_qa & bits_a[PORT_W-1:0]);
  end

  // ---------------- read and output stages ----------------
  logic [PORT_W-1:0] rd_a;
  logic [PORT_W-1:0] rd_b;
  logic [PORT_W-1:0] oreg_a;
  logic [PORT_W-1:0] oreg_b;

  always_ff @(posedge hclk or negedge rst_a_n)
  begin
    if (!rst_a_n)
    begin
      rd_a <= '0;
      oreg_a <= '0;
      dout_a <= '0;
    end
    else
    begin
      if (comb && acc_b && !we_qb)
        rd_a <= mem[lo_b];
      else if (!comb && acc_a && !we_qa)
        rd_a <= mem[addr_qa];
      if (out_a)
        oreg_a <= rd_a;
      dout_a <= cfg[CFG_BYP_A] ? rd_a : oreg_a;
    end
  end

  always_ff @(posedge hclk or negedge rst_b_n)
  begin
    if (!rst_b_n)
    begin
      rd_b <= '0;
      oreg_b <= '0;
      dout_b <= '0;
    end
    else
    begin
      if (acc_b && !we_qb)
        rd_b <= comb ? mem[hi_b] : mem[addr_qb];
      if (out_b)
        oreg_b <= rd_b;
      dout_b <= cfg[CFG_BYP_B] ? rd_b : oreg_b;
    end
  end

  // write counters for software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
    end
    else
    begin
      cnt_a <= cnt_a + {15'h0000, wr_a};
      cnt_b <= cnt_b + {15'h0000, wr_b};
    end
  end

  // ---------------- checks ----------------
  sequence s_read_a;
    acc_a && !we_qa && !comb;
  endsequence
  sequence s_read_done_a(logic [PORT_W-1:0] w);
    rd_a == w;
  endsequence

  AST_MASKED_LANE_KEPT: assert property (@(posedge hclk) disable iff (!rst_a_n)
    wr_a && !comb && !(wr_b && addr_qb == addr_qa)
    |=> ((mem[$past(addr_qa)] ^ $past(mem[addr_qa])) & ~$past(bits_a[PORT_W-1:0])) == '0)
    else $error("masked-off lane changed on write");
  AST_NO_WRITE_ON_READ: assert property (@(posedge hclk) disable iff (!rst_a_n)
    acc_a && !we_qa && !comb && !(wr_b && addr_qb == addr_qa)
    |=> mem[$past(addr_qa)] == $past(mem[addr_qa]))
    else $error("read access changed the addressed word");
  AST_FULL_MASK: assert property (@(posedge hclk) disable iff (!rst_a_n)
    wr_a && !comb && nine && mask_qa == 8'hff && cfg[CFG_WIDTH_LSB +: 2] == WIDTH_X72
    |-> bits_a[PORT_W-1:0] == {PORT_W{1'b1}})
    else $error("all-high mask did not open every lane");
  AST_X18_LANES: assert property (@(posedge hclk) disable iff (!rst_a_n)
    !comb && cfg[CFG_WIDTH_LSB +: 2] == WIDTH_X18 |-> bits_a[WIDE_W-1:18] == '0)
    else $error("x18 mode opened lanes above bit 17");
  AST_LANE_ZERO: assert property (@(posedge hclk) disable iff (!rst_a_n)
    nine |-> bits_a[8:0] == {9{lane_a[0]}} && bits_a[17:9] == {9{lane_a[1]}})
    else $error("nine-bit lane 0 or 1 misplaced");
  AST_LANE_TOP: assert property (@(posedge hclk) disable iff (!rst_a_n)
    comb && nine |-> bits_a[143:135] == {9{mask_qb[7]}} && bits_a[80:72] == {9{mask_qb[0]}})
    else $error("joined mask lane 8 or 15 misplaced");
  AST_EIGHT_BIT: assert property (@(posedge hclk) disable iff (!rst_a_n)
    !nine |-> bits_a[7:0] == {8{lane_a[0]}} && bits_a[15:8] == {8{lane_a[1]}})
    else $error("eight-bit lane misplaced");
  AST_INPUT_CLOCK: assert property (@(posedge hclk) disable iff (!rst_a_n)
    addr_qa != $past(addr_qa) && $past(rst_a_n) |-> $past(in_a))
    else $error("port a input register moved without its clock");
  AST_BYPASS: assert property (@(posedge hclk) disable iff (!rst_a_n)
    $past(cfg[CFG_BYP_A]) && $past(rst_a_n) |-> dout_a == $past(rd_a))
    else $error("bypassed output does not follow read stage");
  AST_READ_A: assert property (@(posedge hclk) disable iff (!rst_a_n)
    s_read_a |=> s_read_done_a($past(mem[addr_qa])))
    else $error("read did not return the addressed word");
  AST_CLEAR_A: assert property (@(posedge hclk) disable iff (!hresetn)
    clr_a |-> dout_a == '0 && addr_qa == '0 && !acc_a)
    else $error("port a registers not held clear");
endmodule // dual_port_ram_byte_enable
`default_nettype wire

/* test/fabric_port.sv */
`timescale 1ns/1ps
`default_nettype none
module fabric_port
#(
  parameter int AW = 4
)
(
  // fabric clock
  input wire logic hclk,
  // port controls and data
  output logic tick,
  output logic clocken,
  output logic wsel,
  output logic [AW-1:0] addr,
  output logic [71:0] din,
  output logic [7:0] bmask
);
  initial
  begin
    {tick, clocken, wsel, addr, din, bmask} = '0;
  end

  task automatic access(input logic w, input logic en, input logic [AW-1:0] a,
                        input logic [71:0] d, input logic [7:0] m, input int n);
    @(posedge hclk);
    tick <= 1'b1;
    clocken <= en;
    wsel <= w;
    addr <= a;
    din <= d;
    bmask <= m;
    repeat (n) @(posedge hclk);
    tick <= 1'b0;
    clocken <= 1'b0;
    wsel <= 1'b0;
    // released lines flip so a stale copy cannot pass for data
    addr <= ~a;
    din <= ~d;
    bmask <= ~m;
  endtask
endmodule // fabric_port
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  import dpram_pkg::*;
  localparam int AW = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr_a, clr_b;
  logic [HADDR_W-1:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdv;
  logic tick_a, tick_b, clocken_a, clocken_b, wsel_a, wsel_b;
  logic [AW-1:0] addr_a, addr_b;
  logic [71:0] din_a, din_b, dout_a, dout_b, pat, keep;
  logic [7:0] bmask_a, bmask_b;
  logic [7:0] open_l [3] = '{LANES_X18[7:0], LANES_X36[7:0], LANES_X72[7:0]};
  int fail_count = 0;
  int n_compared = 0;

  assign hready = hreadyout;
  dual_port_ram_byte_enable #(.DEPTH(16)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .tick_a(tick_a), .tick_b(tick_b), .clocken_a(clocken_a), .clocken_b(clocken_b),
    .clr_a(clr_a), .clr_b(clr_b), .wsel_a(wsel_a), .addr_a(addr_a), .din_a(din_a),
    .bmask_a(bmask_a), .dout_a(dout_a), .wsel_b(wsel_b), .addr_b(addr_b), .din_b(din_b),
    .bmask_b(bmask_b), .dout_b(dout_b));
  fabric_port #(.AW(AW)) fa (.hclk(hclk), .tick(tick_a), .clocken(clocken_a), .wsel(wsel_a),
    .addr(addr_a), .din(din_a), .bmask(bmask_a));
  fabric_port #(.AW(AW)) fb (.hclk(hclk), .tick(tick_b), .clocken(clocken_b), .wsel(wsel_b),
    .addr(addr_b), .din(din_b), .bmask(bmask_b));

  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  function automatic logic [71:0] lanes(input logic [7:0] m, input logic nine);
    logic [71:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < (nine ? 9 : 8); j++)
        if (m[i]) r[i * (nine ? 9 : 8) + j] = 1'b1;
    return r;
  endfunction

  // waits are ended only by the watchdog
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic cfg(input logic [8:0] v);
    ahb(1'b1, ADDR_CFG, {23'h0, v});
  endtask

  task automatic wr(input logic en, input logic [AW-1:0] a, input logic [71:0] d,
                    input logic [7:0] m);
    fa.access(1'b1, en, a, d, m, 1);
    repeat (3) @(posedge hclk);
  endtask

  task automatic rd(input logic b, input logic [AW-1:0] a, input logic [71:0] exp);
    if (b) fb.access(1'b0, 1'b1, a, '0, '0, 6);
    else fa.access(1'b0, 1'b1, a, '0, '0, 6);
    // look between edges, where the output has settled
    repeat (4) @(negedge hclk);
    `CHK(b ? dout_b : dout_a, exp)
  endtask

  task automatic conclude();
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    conclude();
  end

  initial
  begin
    {hresetn, hsel, hwrite, clr_a, clr_b, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    pat = 72'h12_3456_789a_bcde_f0a5;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(negedge hclk);
    `CHK(hreadyout, 1'b1)
    ahb(1'b0, ADDR_CFG, '0);
    `CHK(rdv, {23'h0, CFG_RESET})
    ahb(1'b1, 12'h008, 32'hffff_ffff);
    ahb(1'b0, 12'h008, '0);
    `CHK(rdv, 32'h0000_0000)
    `CHK(hresp, 1'b0)
    cfg(9'h136);
    wr(1'b1, 1, pat, 8'hff);
    rd(1'b1, 1, pat);
    keep = pat;
    for (int i = 0; i < 8; i++)
    begin
      wr(1'b1, 1, ~pat, 8'h01 << i);
      keep = (~pat & lanes(8'h01 << i, 1'b1)) | (keep & ~lanes(8'h01 << i, 1'b1));
      rd(1'b0, 1, keep);
    end
    wr(1'b1, 1, pat, 8'h5a);
    keep = (pat & lanes(8'h5a, 1'b1)) | (keep & ~lanes(8'h5a, 1'b1));
    rd(1'b0, 1, keep);
    wr(1'b0, 1, '0, 8'hff);
    wr(1'b1, 1, '0, 8'h00);
    rd(1'b1, 1, keep);
    for (int w = 0; w < 3; w++)
    begin
      cfg(9'h136);
      wr(1'b1, 2, '0, 8'hff);
      cfg(9'h134 | 9'(w));
      wr(1'b1, 2, '1, 8'hff);
      rd(1'b0, 2, lanes(open_l[w], 1'b1));
    end
    cfg(9'h136);
    wr(1'b1, 3, '0, 8'hff);
    cfg(9'h132);
    wr(1'b1, 3, '1, 8'h81);
    rd(1'b0, 3, lanes(8'h81, 1'b0));
    cfg(9'h106);
    rd(1'b0, 1, keep);
    rd(1'b1, 1, keep);
    @(posedge hclk);
    clr_a <= 1'b1;
    repeat (2) @(negedge hclk);
    `CHK(dout_a, 72'h00_0000_0000_0000_0000)
    `CHK(dout_b, keep)
    @(posedge hclk);
    clr_a <= 1'b0;
    rd(1'b0, 1, keep);
    cfg(9'h136);
    wr(1'b1, 4, '0, 8'hff);
    wr(1'b1, 5, '0, 8'hff);
    cfg(9'h03e);
    fork
      fa.access(1'b1, 1'b1, 4, pat, 8'h01, 1);
      fb.access(1'b0, 1'b1, 0, ~pat, 8'h81, 1);
    join
    repeat (3) @(posedge hclk);
    cfg(9'h136);
    rd(1'b1, 4, pat & lanes(8'h01, 1'b1));
    rd(1'b1, 5, ~pat & lanes(8'h81, 1'b1));
    cfg(9'h136);
    wr(1'b1, 6, '0, 8'hff);
    // both stages on clock b: a port a tick alone must not capture
    cfg(9'h0c6);
    wr(1'b1, 6, pat, 8'hff);
    fork
      fa.access(1'b1, 1'b1, 6, pat, 8'h0f, 1);
      fb.access(1'b0, 1'b0, 6, '0, '0, 1);
    join
    repeat (3) @(posedge hclk);
    fork
      fa.access(1'b0, 1'b1, 6, '0, '0, 6);
      fb.access(1'b0, 1'b0, 6, '0, '0, 6);
    join
    repeat (4) @(negedge hclk);
    `CHK(dout_a, pat & lanes(8'h0f, 1'b1))
    ahb(1'b0, ADDR_STAT, '0);
    `CHK(rdv, 32'h0000_0018)
    conclude();
  end
endmodule // testbench
`default_nettype wire
